// *** sras_pkg.sv ***
// Package: constants for the serial register access slave.
// Assumes byte framing (start/stop bits, gap detection) is done outside.
package sras_pkg;
    localparam logic [7:0]  FN_READ      = 8'h03;
    localparam logic [7:0]  FN_LOOP      = 8'h08;
    localparam logic [7:0]  FN_WRITE     = 8'h10;
    localparam logic [7:0]  FN_ERR_BIT   = 8'h80;
    localparam logic [7:0]  ERR_FUNC     = 8'h01;
    localparam logic [7:0]  ERR_ADDR     = 8'h02;
    localparam logic [7:0]  ERR_QTY      = 8'h03;
    localparam logic [7:0]  BCAST_ADDR   = 8'h00;
    localparam logic [15:0] CRC_PRESET   = 16'hffff;
    localparam logic [15:0] CRC_POLY     = 16'ha001;
    localparam int          RX_MAX       = 41;
    localparam int          QTY_MAX      = 16;
    localparam int          FIXED_LEN    = 8;
    localparam int          WR_HDR_LEN   = 9;
    localparam int          WR_RSP_LEN   = 6;
    localparam int          RD_HDR_LEN   = 3;
    localparam int          ERR_LEN      = 3;
    localparam logic [7:0]  WAIT_MS_DEF  = 8'h05;
    localparam int          CLK_HZ       = 40000000;
    localparam int          MS_PER_S     = 1000;
    localparam int          CYC_PER_MS   = CLK_HZ / MS_PER_S;
endpackage

// *** sras_crc_if.sv ***
// Interface: byte feed into a CRC-16 engine and its running value.
// Assumes one user and one engine on the same clock.
`timescale 1ns/1ps
interface sras_crc_if;
    logic        clr;
    logic        en;
    logic [7:0]  din;
    logic [15:0] crc;
    logic [15:0] next_crc;
    modport user   (output clr, output en, output din, input crc, input next_crc);
    modport engine (input clr, input en, input din, output crc, output next_crc);
endinterface

// *** sras_crc16.sv ***
// Byte-wide CRC-16, reflected, preset all ones on clear.
// Assumes clr and en are not raised together.
`timescale 1ns/1ps
module sras_crc16 (
    // Clock and reset
    input wire logic   sys_clk,
    input wire logic   rst,
    // Feed
    sras_crc_if.engine c
);
    always_comb begin
        logic [15:0] v;
        v = c.crc ^ {8'h00, c.din};
        for (int i = 0; i < 8; i++) begin
            v = v[0] ? ((v >> 1) ^ sras_pkg::CRC_POLY) : (v >> 1);
        end
        c.next_crc = v;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            c.crc <= sras_pkg::CRC_PRESET;
        end else if (c.clr) begin
            c.crc <= sras_pkg::CRC_PRESET;
        end else if (c.en) begin
            c.crc <= c.next_crc;
        end
    end
endmodule

// *** sras_slave.sv ***
// Command interpreter of a serial register access slave: receives a framed
// command, checks it, acts on the register store and sends the response.
// Assumes bytes arrive as valid pulses and rx_end pulses after the last byte.
//
// Notes on behaviour
// - A read command returns a run of consecutive registers from the start address.
// - Each read register goes out high byte then low byte, in ascending address order.
// - Byte counts in a multiple write and in a read response are twice the quantity.
// - A loopback command is answered with the received message unchanged.
// - A multiple write stores each word into consecutive registers from the start address.
// - Address zero is a broadcast that is acted upon but never answered.
// - Both CRCs start from all ones and every received frame is CRC checked.
// - The response starts only after a programmable wait, five milliseconds by default.
`timescale 1ns/1ps
module sras_slave #(
    parameter int NREG       = 64,
    parameter int CYC_PER_MS = sras_pkg::CYC_PER_MS
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Configuration
    input  wire logic [7:0] my_addr,
    input  wire logic [7:0] send_wait_ms,
    // Receive byte stream
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_end,
    // Transmit byte stream
    output logic            tx_valid,
    output logic [7:0]      tx_data,
    input  wire logic       tx_ready,
    // Status
    output logic            busy
);
    localparam int AW = $clog2(NREG);

    typedef enum logic [6:0] {
        S_IDLE  = 7'b0000001, S_CHECK = 7'b0000010, S_WRITE = 7'b0000100,
        S_WAIT  = 7'b0001000, S_SEND  = 7'b0010000, S_CRCLO = 7'b0100000,
        S_CRCHI = 7'b1000000
    } sras_state_t;

    typedef enum logic [2:0] {
        R_READ = 3'b001, R_ECHO = 3'b010, R_ERR = 3'b100
    } sras_rsp_t;

    sras_state_t state;
    sras_rsp_t   rsp;
    logic [7:0]  rx_buf [sras_pkg::RX_MAX];
    logic [15:0] regs   [NREG];
    logic [5:0]  rx_cnt, tx_idx, tx_len, next_idx;
    logic        rx_ovf, bcast;
    logic [7:0]  err_code, next_byte, crc_hi;
    logic [4:0]  widx;
    logic [31:0] wait_cnt;

    sras_crc_if rxc();
    sras_crc_if txc();
    sras_crc16 u_rx_crc (.sys_clk(sys_clk), .rst(rst), .c(rxc));
    sras_crc16 u_tx_crc (.sys_clk(sys_clk), .rst(rst), .c(txc));

    wire [7:0]  f_addr = rx_buf[0];
    wire [7:0]  f_func = rx_buf[1];
    wire [15:0] f_start = {rx_buf[2], rx_buf[3]};
    wire [15:0] f_qty = {rx_buf[4], rx_buf[5]};
    wire [7:0]  f_bc = rx_buf[6];
    wire        f_mine = (f_addr == my_addr) || (f_addr == sras_pkg::BCAST_ADDR);
    wire [16:0] f_end = {1'b0, f_start} + {1'b0, f_qty};
    wire        tx_fire = tx_valid && tx_ready;
    wire        f_drop = (rx_cnt < 6'd4) || rx_ovf || (rxc.crc != 16'h0000) || !f_mine;
    wire        f_wr_ok = (err_code == 8'h00) && (f_func == sras_pkg::FN_WRITE);
    wire        f_quiet = f_drop || (f_addr == sras_pkg::BCAST_ADDR && !f_wr_ok);

    ////////////////////////////////////////////////////////////////////////
    // Command check
    always_comb begin
        err_code = 8'h00;
        if (f_func == sras_pkg::FN_READ) begin
            if (f_qty == 16'h0000 || f_qty > 16'(sras_pkg::QTY_MAX)
                || rx_cnt != 6'(sras_pkg::FIXED_LEN)) err_code = sras_pkg::ERR_QTY;
            else if (f_end > 17'(NREG)) err_code = sras_pkg::ERR_ADDR;
        end else if (f_func == sras_pkg::FN_WRITE) begin
            if (f_qty == 16'h0000 || f_qty > 16'(sras_pkg::QTY_MAX)
                || {8'h00, f_bc} != {f_qty[14:0], 1'b0}
                || rx_cnt != 6'(sras_pkg::WR_HDR_LEN + 32'(f_bc))) err_code = sras_pkg::ERR_QTY;
            else if (f_end > 17'(NREG)) err_code = sras_pkg::ERR_ADDR;
        end else if (f_func == sras_pkg::FN_LOOP) begin
            if (rx_cnt != 6'(sras_pkg::FIXED_LEN)) err_code = sras_pkg::ERR_QTY;
        end else begin
            err_code = sras_pkg::ERR_FUNC;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Response byte source
    assign next_idx = tx_idx + 6'd1;
    always_comb begin
        logic [5:0]  k;
        logic [AW-1:0] ra;
        k = (state == S_WAIT) ? 6'd0 : next_idx;
        ra = AW'(f_start + 16'((k - 6'(sras_pkg::RD_HDR_LEN)) >> 1));
        next_byte = rx_buf[k];
        case (rsp)
            R_ERR: begin
                if (k == 6'd1) next_byte = f_func | sras_pkg::FN_ERR_BIT;
                else if (k == 6'd2) next_byte = err_code;
            end
            R_READ: begin
                if (k == 6'd2) next_byte = {f_qty[6:0], 1'b0};
                else if (k >= 6'(sras_pkg::RD_HDR_LEN))
                    next_byte = k[0] ? regs[ra][15:8] : regs[ra][7:0];
            end
            default: next_byte = rx_buf[k];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer and CRC feed
    assign rxc.clr = (state == S_CHECK);
    assign rxc.en  = (state == S_IDLE) && rx_valid;
    assign rxc.din = rx_data;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_cnt <= 6'd0;
            rx_ovf <= 1'b0;
        end else if (state == S_IDLE) begin
            if (rx_valid) begin
                if (rx_cnt < 6'(sras_pkg::RX_MAX)) rx_buf[rx_cnt] <= rx_data;
                else rx_ovf <= 1'b1;
                if (rx_cnt < 6'(sras_pkg::RX_MAX)) rx_cnt <= rx_cnt + 6'd1;
            end
        end else if (state == S_CHECK) begin
            rx_ovf <= 1'b0;
            if (f_quiet) rx_cnt <= 6'd0;
        end else if (state == S_CRCHI && tx_fire || state == S_WRITE && bcast) begin
            rx_cnt <= 6'd0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    assign txc.clr = (state == S_WAIT);
    assign txc.en  = (state == S_SEND) && tx_fire;
    assign txc.din = tx_data;
    assign tx_valid = (state == S_SEND) || (state == S_CRCLO) || (state == S_CRCHI);
    assign busy = (state != S_IDLE);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state    <= S_IDLE;
            rsp      <= R_ECHO;
            bcast    <= 1'b0;
            tx_idx   <= 6'd0;
            tx_len   <= 6'd0;
            tx_data  <= 8'h00;
            crc_hi   <= 8'h00;
            widx     <= 5'd0;
            wait_cnt <= 32'h0;
        end else begin
            case (state)
                S_IDLE: if (rx_end) state <= S_CHECK;
                S_CHECK: begin
                    bcast    <= (f_addr == sras_pkg::BCAST_ADDR);
                    widx     <= 5'd0;
                    wait_cnt <= 32'(send_wait_ms) * 32'(CYC_PER_MS);
                    rsp      <= (err_code != 8'h00) ? R_ERR
                              : (f_func == sras_pkg::FN_READ) ? R_READ : R_ECHO;
                    // loopback echo length is frame without CRC, write echo is six bytes
                    tx_len   <= (err_code != 8'h00) ? 6'(sras_pkg::ERR_LEN)
                              : (f_func == sras_pkg::FN_READ)
                                ? 6'(sras_pkg::RD_HDR_LEN) + {f_qty[4:0], 1'b0}
                              : (f_func == sras_pkg::FN_WRITE) ? 6'(sras_pkg::WR_RSP_LEN)
                              : rx_cnt - 6'd2;
                    if (f_drop) begin
                        state <= S_IDLE;
                    end else if (f_wr_ok) begin
                        state <= S_WRITE;
                    end else if (f_addr == sras_pkg::BCAST_ADDR) begin
                        state <= S_IDLE;
                    end else begin
                        state <= S_WAIT;
                    end
                end
                S_WRITE: begin
                    widx <= widx + 5'd1;
                    if (6'(widx) + 6'd1 == f_qty[5:0]) state <= bcast ? S_IDLE : S_WAIT;
                end
                S_WAIT: begin
                    if (wait_cnt <= 32'd1) begin
                        state   <= S_SEND;
                        tx_idx  <= 6'd0;
                        tx_data <= next_byte;
                    end else begin
                        wait_cnt <= wait_cnt - 32'd1;
                    end
                end
                S_SEND: if (tx_fire) begin
                    tx_idx <= next_idx;
                    if (next_idx == tx_len) begin
                        state   <= S_CRCLO;
                        tx_data <= txc.next_crc[7:0];
                        crc_hi  <= txc.next_crc[15:8];
                    end else begin
                        tx_data <= next_byte;
                    end
                end
                S_CRCLO: if (tx_fire) begin
                    state   <= S_CRCHI;
                    tx_data <= crc_hi;
                end
                S_CRCHI: if (tx_fire) state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register store
    // consecutive words from start
    always_ff @(posedge sys_clk) begin
        if (state == S_WRITE)
            regs[AW'(f_start + 16'(widx))] <= {rx_buf[7 + 2 * widx], rx_buf[8 + 2 * widx]};
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_last_data;
        state == S_SEND && tx_fire && next_idx == tx_len;
    endsequence
    sequence s_crc_tail;
        state == S_CRCLO && tx_data == txc.crc[7:0] && crc_hi == txc.crc[15:8];
    endsequence
    property p_bcast_silent;
        @(posedge sys_clk) disable iff (rst) tx_valid |-> !bcast;
    endproperty
    a_bcast_silent: assert property (p_bcast_silent) else $error("broadcast answered");

    property p_bad_crc;
        @(posedge sys_clk) disable iff (rst)
            state == S_CHECK && rxc.crc != 16'h0000 |=> state == S_IDLE;
    endproperty
    a_bad_crc: assert property (p_bad_crc) else $error("bad CRC accepted");

    property p_crc_preset;
        @(posedge sys_clk) disable iff (rst)
            $rose(state == S_SEND) |-> txc.crc == sras_pkg::CRC_PRESET;
    endproperty
    a_crc_preset: assert property (p_crc_preset) else $error("tx CRC not preset");

    property p_wait_load;
        @(posedge sys_clk) disable iff (rst)
            $rose(state == S_WAIT) |-> wait_cnt == 32'(send_wait_ms) * 32'(CYC_PER_MS);
    endproperty
    a_wait_load: assert property (p_wait_load) else $error("wait not loaded");

    property p_err_func;
        @(posedge sys_clk) disable iff (rst)
            state == S_SEND && rsp == R_ERR && tx_idx == 6'd1
            |-> tx_data == (f_func | sras_pkg::FN_ERR_BIT);
    endproperty
    a_err_func: assert property (p_err_func) else $error("error code top bit");

    property p_read_count;
        @(posedge sys_clk) disable iff (rst)
            state == S_SEND && rsp == R_READ && tx_idx == 6'd2
            |-> tx_data == {f_qty[6:0], 1'b0} && tx_len == 6'd3 + tx_data[5:0];
    endproperty
    a_read_count: assert property (p_read_count) else $error("read byte count");

    property p_read_first;
        @(posedge sys_clk) disable iff (rst)
            state == S_SEND && rsp == R_READ && tx_idx == 6'd3
            |-> tx_data == regs[AW'(f_start)][15:8];
    endproperty
    a_read_first: assert property (p_read_first) else $error("read high byte");

    property p_echo;
        @(posedge sys_clk) disable iff (rst)
            state == S_SEND && rsp == R_ECHO |-> tx_data == rx_buf[tx_idx];
    endproperty
    a_echo: assert property (p_echo) else $error("echo altered");

    property p_crc_tail;
        @(posedge sys_clk) disable iff (rst) s_last_data |=> s_crc_tail;
    endproperty
    a_crc_tail: assert property (p_crc_tail) else $error("CRC not after data");
endmodule

// *** sras_master_model.sv ***
// Bus master model: sends ready-made command frames and sinks replies.
// Assumes the bench supplies every frame complete with its CRC bytes.
`timescale 1ns/1ps
module sras_master_model (
    // Clock
    input  wire logic       sys_clk,
    // Command stream into the slave
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_end,
    // Reply stream out of the slave
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    logic [7:0] got[$];
    bit         slow;
    bit         armed;
    int         cnt;
    int         lat;

    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_end   = 1'b0;
        tx_ready = 1'b1;
        slow     = 1'b0;
        armed    = 1'b0;
        cnt      = 0;
        lat      = 0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // bytes go out in frame order
    task automatic send(input logic [7:0] f[$]);
        foreach (f[i]) begin
            @(posedge sys_clk);
            rx_valid <= 1'b1;
            rx_data  <= f[i];
        end
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        // Released line shows the inverse, so a stale byte is never reread
        rx_data  <= ~rx_data;
        rx_end   <= 1'b1;
        @(posedge sys_clk);
        rx_end <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Slow mode stalls every other cycle to stress the hold of tx_data
    always @(posedge sys_clk) begin
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
        tx_ready <= slow ? ~tx_ready : 1'b1;
        cnt = cnt + 1;
        if (rx_end) begin
            cnt   = 0;
            armed = 1'b1;
        end else if (armed && tx_valid) begin
            lat   = cnt;
            armed = 1'b0;
        end
    end
endmodule

// *** serial_register_access_slave_bench.sv ***
// Testbench of the serial register access slave: table of commands first,
// then bad CRC, broadcast, stalled sink and reply delay by hand.
// Assumes the master model beside it and a short millisecond for speed.
`timescale 1ns/1ps
module serial_register_access_slave_bench;
    typedef logic [7:0] sras_bq_t[$];
    typedef struct {
        int           nc;
        logic [127:0] c;
        int           nr;
        logic [127:0] r;
    } sras_row_t;
    localparam int CPM = 10;
    logic       sys_clk, rst, rx_valid, rx_end, tx_valid, tx_ready, busy;
    logic [7:0] my_addr, send_wait_ms, rx_data, tx_data;
    int         mismatches = 0;
    int         n_compared = 0;
    sras_row_t  rows[9];

    sras_slave #(.NREG(64), .CYC_PER_MS(CPM)) DUT (
        .sys_clk(sys_clk), .rst(rst), .my_addr(my_addr), .send_wait_ms(send_wait_ms),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .busy(busy));
    sras_master_model M (
        .sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic sras_bq_t bytes(logic [127:0] v, int n);
        sras_bq_t q;
        for (int i = 0; i < n; i++)
            q.push_back(v[8*(n-1-i) +: 8]);
        return q;
    endfunction

    // preset all ones, low byte sent first
    function automatic sras_bq_t with_crc(sras_bq_t q);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        return q;
    endfunction

    task automatic check(logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Waits for busy to drop under a bound, then compares every reply byte
    task automatic run(sras_bq_t cmd, sras_bq_t exp);
        int k;
        M.got.delete();
        M.send(cmd);
        repeat (3) @(posedge sys_clk);
        k = 0;
        while (busy !== 1'b0 && k < 2000) begin
            @(posedge sys_clk);
            k++;
        end
        check(16'(k < 2000), 16'h0001);
        repeat (2) @(posedge sys_clk);
        check(16'(M.got.size()), 16'(exp.size()));
        foreach (exp[i])
            if (i < M.got.size())
                check({8'h00, M.got[i]}, {8'h00, exp[i]});
    endtask

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sras_bq_t q;
        sras_bq_t none;
        // write two words, byte count four
        rows[0] = '{11, 128'h0110_0001_0002_04_0001_0258, 6, 128'h0110_0001_0002};
        // read them back in address order
        rows[1] = '{6, 128'h0103_0001_0002, 7, 128'h0103_04_0001_0258};
        // loopback with plain and odd test values
        rows[2] = '{6, 128'h0108_0000_a537, 6, 128'h0108_0000_a537};
        rows[3] = '{6, 128'h0108_ffff_1234, 6, 128'h0108_ffff_1234};
        // unknown function, range, zero quantity, byte count, write range
        rows[4] = '{6, 128'h0105_0001_0002, 3, 128'h0185_01};
        rows[5] = '{6, 128'h0103_003f_0002, 3, 128'h0183_02};
        rows[6] = '{6, 128'h0103_0000_0000, 3, 128'h0183_03};
        rows[7] = '{11, 128'h0110_0000_0001_04_0000_0000, 3, 128'h0190_03};
        rows[8] = '{11, 128'h0110_003f_0002_04_0000_0000, 3, 128'h0190_02};
        rst          = 1'b1;
        my_addr      = 8'h01;
        send_wait_ms = sras_pkg::WAIT_MS_DEF;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        check({15'h0000, tx_valid}, 16'h0000);
        check({15'h0000, busy}, 16'h0000);
        check({8'h00, tx_data}, 16'h0000);
        foreach (rows[i])
            run(with_crc(bytes(rows[i].c, rows[i].nc)),
                with_crc(bytes(rows[i].r, rows[i].nr)));
        // corrupted CRC byte is dropped without reply
        q = with_crc(bytes(128'h0103_0001_0002, 6));
        q[7] = q[7] ^ 8'h01;
        run(q, none);
        // broadcast write stored but silent, then read back
        run(with_crc(bytes(128'h0008_0000_1111, 6)), none);
        run(with_crc(bytes(128'h0010_0005_0001_02_abcd, 9)), none);
        M.slow = 1'b1;
        run(with_crc(bytes(128'h0103_0005_0001, 6)),
            with_crc(bytes(128'h0103_02_abcd, 5)));
        // reply delay of five short milliseconds
        check(16'(M.lat >= int'(sras_pkg::WAIT_MS_DEF) * CPM
                  && M.lat <= int'(sras_pkg::WAIT_MS_DEF) * CPM + 10), 16'h0001);
        wrap_up();
    end
endmodule
